// File: sim/host_model.sv
// host controller model: limit terminals, analog reference, pair select
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output logic [3:0] term_in_n,
    output logic signed [11:0] force_ref_analog,
    output logic mode_select_in_n
);
    // all terminals released at start
    initial begin
        term_in_n = 4'hf;
        force_ref_analog = 12'sh000;
        mode_select_in_n = 1'b1;
    end
    // new levels just after an edge, held until the next call
    task automatic drive(input logic [3:0] low, input logic signed [11:0] ana, input logic sel_n);
        @(posedge clk);
        term_in_n <= ~low;
        force_ref_analog <= ana;
        mode_select_in_n <= sel_n;
    endtask : drive
endmodule : host_model

// File: sim/testbench.sv
// self-checking bench for the force limit selector
`timescale 1ns/1ps
module testbench;
    import force_limit_pkg::*;
    typedef struct packed {
        logic [9:0] f;
        logic [9:0] r;
        logic n;
        logic ff;
        logic [2:0] t;
        logic [2:0] m;
        logic [15:0] o;
    } exp_s;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic chk = 1'b0;
    logic [1:0] opt = 2'h0;
    logic [3:0] pair = 4'h0;
    logic [3:0] alloc = 4'h0;
    logic [7:0] gain = 8'h0a;
    logic [9:0] inf = 10'h320, inr = 10'h320, ef = 10'h064, er = 10'h064, mm = 10'h12c;
    logic signed [15:0] cmd = 16'sh0000;
    logic [3:0] tin;
    logic signed [11:0] ana;
    logic msel, flag_n, ff;
    logic [9:0] fl, rl;
    logic [15:0] fo;
    logic [2:0] ot;
    ctrl_mode_e cm;
    exp_s q[$];
    exp_s me;
    int fails = 0, tests_run = 0;
    logic [7:0] gains[4] = '{8'h0a, 8'h14, 8'h32, 8'h64};
    logic [3:0] codes[8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb};
    ctrl_mode_e lo_m[8] = '{MODE_INT_SPEED, MODE_INT_SPEED, MODE_INT_SPEED, MODE_SPEED,
        MODE_FORCE, MODE_SPEED, MODE_ZERO_CLAMP, MODE_INHIBIT};
    ctrl_mode_e hi_m[8] = '{MODE_SPEED, MODE_POSITION, MODE_FORCE, MODE_POSITION,
        MODE_POSITION, MODE_FORCE, MODE_SPEED, MODE_POSITION};
    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    host_model host_model_inst (.clk(clk), .term_in_n(tin), .force_ref_analog(ana),
        .mode_select_in_n(msel));
    force_limit_selector force_limit_selector_inst (.clk(clk), .srst(srst), .term_in_n(tin),
        .fwd_limit_term_sel(2'h0), .rev_limit_term_sel(2'h1), .fwd_limit_extra_map(4'h4),
        .rev_limit_extra_map(4'h8), .force_ref_analog(ana), .force_cmd(cmd),
        .speed_ctrl_option_param(opt), .force_ref_gain_param(gain),
        .fwd_external_limit_param(ef), .rev_external_limit_param(er),
        .fwd_internal_limit_param(inf), .rev_internal_limit_param(inr), .motor_max_force(mm),
        .output_signal_alloc_param(alloc), .control_mode_pair_param(pair),
        .mode_select_in_n(msel), .force_out(fo), .fwd_limit_eff(fl), .rev_limit_eff(rl),
        .out_term_n(ot), .force_limited_out_n(flag_n), .ff_enable(ff), .ctrl_mode(cm));
    // expected effective limit in percent
    function automatic logic [9:0] lim(input logic [9:0] il, ex, input logic on,
        input logic [9:0] ap);
        logic [9:0] l;
        l = il;
        if (on && ex < l) l = ex;
        if ((opt == 2'h1 || (opt == 2'h3 && on)) && pair != 4'h2 && ap < l) l = ap;
        if (mm < l) l = mm;
        return l;
    endfunction : lim
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            fails++;
            $display("ERROR %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask : check
    // note the expected outputs, then flag the monitor for one cycle
    task automatic post(input string name, input logic [9:0] f, r, input logic [2:0] m);
        logic [2:0] t;
        logic n;
        logic [15:0] o;
        n = (cmd == 16'sh0000);
        t = 3'h7;
        if (alloc != 4'h0) t[alloc-1] = n;
        // full-scale command clamps to the limit, 100 percent = 4096
        o = (cmd == 16'sh0000) ? 16'h0000 :
            cmd[15] ? 16'(-({r, 12'h000} / 32'h64)) : 16'({f, 12'h000} / 32'h64);
        q.push_back({f, r, n, opt == 2'h2 && pair != 4'h2, t, m, o});
        chk <= 1'b1;
        @(posedge clk);
        chk <= 1'b0;
        $display("test %s done", name);
    endtask : post
    task automatic test_done();
        $display("compares %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    // compare settled outputs with the oldest note
    always @(negedge clk) begin
        if (chk) begin
            me = q.pop_front();
            check(fl, me.f);
            check(rl, me.r);
            check(flag_n, me.n);
            check(ff, me.ff);
            check(ot, me.t);
            check(fo, me.o);
            check(cm, me.m);
        end
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        test_done();
    end
    // main sequence
    initial begin
        logic [3:0] low;
        logic [7:0] g;
        logic signed [11:0] av;
        int k;
        void'($urandom(32'h5d8a0f3e));
        repeat (12) @(posedge clk);
        post("reset", 10'h01e, 10'h01e, MODE_SPEED);
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            g = gains[i % 4];
            k = $urandom_range(80);
            low = 4'($urandom_range(15));
            av = 12'(k * 10);
            if (k[0]) av = -av;
            opt <= i[3] ? {i[0], 1'b1} : i[1:0];
            pair <= i[3] ? 4'h2 : {3'h0, i[2]};
            gain <= g;
            alloc <= {2'h0, i[2:1]};
            inf <= 10'($urandom_range(800));
            inr <= 10'($urandom_range(800));
            ef <= 10'($urandom_range(800));
            er <= 10'($urandom_range(800));
            mm <= i[2] ? 10'h12c : 10'h0c8;
            cmd <= (i == 5) ? 16'sh0000 : (i[0] ? 16'sh7fff : 16'sh8000);
            host_model_inst.drive(low, av, 1'b1);
            repeat (8) @(posedge clk);
            post("limit", lim(inf, ef, low[0] | low[2], 10'(k * 100 / g)),
                lim(inr, er, low[1] | low[3], 10'(k * 100 / g)),
                i[3] ? MODE_FORCE : (i[2] ? MODE_POSITION : MODE_SPEED));
        end
        opt <= 2'h0;
        cmd <= 16'sh0000;
        for (int j = 0; j < 16; j++) begin
            pair <= codes[j / 2];
            host_model_inst.drive(4'h0, 12'sh000, j[0]);
            repeat (8) @(posedge clk);
            post("mode", lim(inf, ef, 1'b0, 10'h000), lim(inr, er, 1'b0, 10'h000),
                j[0] ? hi_m[j / 2] : lo_m[j / 2]);
        end
        test_done();
    end
endmodule : testbench

// File: src/force_limit_pkg.sv
// constants and types for the force limit selector
//
// Overview of operation
// - option 1: analog input is force limit
// - option 2: feed-forward, never with analog limit
// - analog limit scaled by gain up to 10 V
// - option 3: analog limit only with enabled input
// - no analog limiting in force control
// - combined mode takes smaller of analog, external
// - external limits 0..800 percent, default 100
// - forward limit minimum when forward input low
// - reverse limit minimum when reverse input low
// - shared terminal signals combine by OR
// - limited flag low while force is clamped
// - flag reaches terminal only when allocated
// - modes 4,5,6 pair internal speed with others
// - modes 8 and 9 pairings
// - modes A and B pairings
// - analog limit uses absolute input value
// - limits above motor maximum use motor maximum
// - internal limits always on, default 30
// - limit inputs registered within 2 ms
package force_limit_pkg;
    localparam int PCT_W = 10;
    localparam logic [PCT_W-1:0] PCT_MAX = 10'h320; // 800 percent
    localparam logic [PCT_W-1:0] EXT_LIMIT_RST = 10'h064; // 100 percent
    localparam logic [PCT_W-1:0] INT_LIMIT_RST = 10'h01e; // 30 percent
    localparam logic [PCT_W-1:0] MOTOR_MAX_RST = 10'h12c; // 300 percent
    localparam logic [7:0] GAIN_MIN = 8'h0a; // 1.0 V per rated force, 0.1 V units
    localparam logic [7:0] GAIN_MAX = 8'h64; // 10.0 V per rated force
    localparam logic [7:0] GAIN_RST = 8'h1e; // 3.0 V
    localparam int CLK_HZ = 40000000;
    localparam int INPUT_DELAY_US = 2000; // 2 ms worst case registration
    localparam int INPUT_DELAY_CYC = INPUT_DELAY_US * (CLK_HZ / 1000000);
    localparam int FILT_CYC = 4; // cycles used, well inside the worst case
    localparam logic [1:0] OPT_NONE = 2'h0;
    localparam logic [1:0] OPT_ANALOG_LIMIT = 2'h1;
    localparam logic [1:0] OPT_FEED_FWD = 2'h2;
    localparam logic [1:0] OPT_COMBINED = 2'h3;
    localparam logic [3:0] ALLOC_NONE = 4'h0;

    typedef enum logic [2:0] {
        MODE_POSITION = 3'b000,
        MODE_SPEED = 3'b001,
        MODE_FORCE = 3'b010,
        MODE_INT_SPEED = 3'b011,
        MODE_ZERO_CLAMP = 3'b100,
        MODE_INHIBIT = 3'b101
    } ctrl_mode_e;
endpackage : force_limit_pkg

// File: src/force_limit_selector.sv
// force limit selection, clamping and control mode pair decode
`timescale 1ns/1ps
module force_limit_selector
    import force_limit_pkg::*;
#(
    parameter int FORCE_W = 16, // signed command, 100 percent = 2**(FORCE_W-4)
    parameter int ANALOG_W = 12, // signed analog sample, lsb = 10 mV
    parameter int NUM_TERM = 4, // input terminals
    parameter int NUM_OUT = 3 // output terminals
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [NUM_TERM-1:0] term_in_n,
    input wire logic [$clog2(NUM_TERM)-1:0] fwd_limit_term_sel,
    input wire logic [$clog2(NUM_TERM)-1:0] rev_limit_term_sel,
    input wire logic [NUM_TERM-1:0] fwd_limit_extra_map,
    input wire logic [NUM_TERM-1:0] rev_limit_extra_map,
    input wire logic signed [ANALOG_W-1:0] force_ref_analog,
    input wire logic signed [FORCE_W-1:0] force_cmd,
    input wire logic [1:0] speed_ctrl_option_param,
    input wire logic [7:0] force_ref_gain_param,
    input wire logic [PCT_W-1:0] fwd_external_limit_param,
    input wire logic [PCT_W-1:0] rev_external_limit_param,
    input wire logic [PCT_W-1:0] fwd_internal_limit_param,
    input wire logic [PCT_W-1:0] rev_internal_limit_param,
    input wire logic [PCT_W-1:0] motor_max_force,
    input wire logic [3:0] output_signal_alloc_param,
    input wire logic [3:0] control_mode_pair_param,
    input wire logic mode_select_in_n,
    output logic signed [FORCE_W-1:0] force_out,
    output logic [PCT_W-1:0] fwd_limit_eff,
    output logic [PCT_W-1:0] rev_limit_eff,
    output logic [NUM_OUT-1:0] out_term_n,
    output logic force_limited_out_n,
    output logic ff_enable,
    output ctrl_mode_e ctrl_mode
);
    localparam logic [2:0] FILT_TOP = 3'(FILT_CYC - 1);

    // or-combine every terminal mapped to each logical limit signal
    wire fwd_raw_on = ~term_in_n[fwd_limit_term_sel] | |(~term_in_n & fwd_limit_extra_map);
    wire rev_raw_on = ~term_in_n[rev_limit_term_sel] | |(~term_in_n & rev_limit_extra_map);

    // short stability filter on the limit inputs
    logic fwd_on_reg, rev_on_reg;
    logic [2:0] fwd_cnt_reg, rev_cnt_reg;
    always_ff @(posedge clk) begin
        if (srst) begin
            fwd_on_reg <= 1'b0;
            rev_on_reg <= 1'b0;
            fwd_cnt_reg <= 3'h0;
            rev_cnt_reg <= 3'h0;
        end else begin
            fwd_cnt_reg <= (fwd_raw_on == fwd_on_reg || fwd_cnt_reg == FILT_TOP) ? 3'h0 :
                fwd_cnt_reg + 3'h1;
            rev_cnt_reg <= (rev_raw_on == rev_on_reg || rev_cnt_reg == FILT_TOP) ? 3'h0 :
                rev_cnt_reg + 3'h1;
            if (fwd_raw_on != fwd_on_reg && fwd_cnt_reg == FILT_TOP) fwd_on_reg <= fwd_raw_on;
            if (rev_raw_on != rev_on_reg && rev_cnt_reg == FILT_TOP) rev_on_reg <= rev_raw_on;
        end
    end

    // control mode pair decode, mode_select_in_n low selects the first member
    ctrl_mode_e mode_next;
    wire sel_on = ~mode_select_in_n;
    wire int_spd = fwd_on_reg | rev_on_reg | sel_on;
    always_comb begin
        unique case (control_mode_pair_param)
            4'h4: mode_next = int_spd ? MODE_INT_SPEED : MODE_SPEED;
            4'h5: mode_next = int_spd ? MODE_INT_SPEED : MODE_POSITION;
            4'h6: mode_next = int_spd ? MODE_INT_SPEED : MODE_FORCE;
            4'h7: mode_next = sel_on ? MODE_SPEED : MODE_POSITION;
            4'h8: mode_next = sel_on ? MODE_FORCE : MODE_POSITION;
            4'h9: mode_next = sel_on ? MODE_SPEED : MODE_FORCE;
            4'ha: mode_next = sel_on ? MODE_ZERO_CLAMP : MODE_SPEED;
            4'hb: mode_next = sel_on ? MODE_INHIBIT : MODE_POSITION;
            4'h0: mode_next = MODE_SPEED;
            4'h1: mode_next = MODE_POSITION;
            4'h2: mode_next = MODE_FORCE;
            default: mode_next = MODE_SPEED;
        endcase
    end

    // analog limit: absolute value scaled by gain into percent
    wire force_mode = (ctrl_mode == MODE_FORCE);
    wire [ANALOG_W-1:0] abs_ref = force_ref_analog[ANALOG_W-1] ?
        ANALOG_W'(-force_ref_analog) : ANALOG_W'(force_ref_analog);
    wire [7:0] gain_c = (force_ref_gain_param < GAIN_MIN) ? GAIN_MIN :
        (force_ref_gain_param > GAIN_MAX) ? GAIN_MAX : force_ref_gain_param;
    // abs in 10 mV, gain in 100 mV: percent = abs*10/gain
    wire [ANALOG_W+3:0] ana_q = (ANALOG_W+4)'((ANALOG_W+4)'(abs_ref) * 16'd10 / gain_c);
    wire [PCT_W-1:0] ana_pct = (ana_q > (ANALOG_W+4)'(PCT_MAX)) ? PCT_MAX : PCT_W'(ana_q);

    wire opt_ana = (speed_ctrl_option_param == OPT_ANALOG_LIMIT);
    wire opt_comb = (speed_ctrl_option_param == OPT_COMBINED);
    wire ana_ok = !force_mode && !ff_enable;
    wire fwd_ana_use = ana_ok && (opt_ana || (opt_comb && fwd_on_reg));
    wire rev_ana_use = ana_ok && (opt_ana || (opt_comb && rev_on_reg));

    function automatic logic [PCT_W-1:0] min2(input logic [PCT_W-1:0] a,
        input logic [PCT_W-1:0] b);
        min2 = (a < b) ? a : b;
    endfunction : min2

    // clamp settings to their range
    wire [PCT_W-1:0] fwd_ext = min2(fwd_external_limit_param, PCT_MAX);
    wire [PCT_W-1:0] rev_ext = min2(rev_external_limit_param, PCT_MAX);
    wire [PCT_W-1:0] fwd_int = min2(fwd_internal_limit_param, PCT_MAX);
    wire [PCT_W-1:0] rev_int = min2(rev_internal_limit_param, PCT_MAX);

    // minimum of all applicable sources, then motor maximum
    wire [PCT_W-1:0] fwd_a = fwd_on_reg ? min2(fwd_int, fwd_ext) : fwd_int;
    wire [PCT_W-1:0] rev_a = rev_on_reg ? min2(rev_int, rev_ext) : rev_int;
    wire [PCT_W-1:0] fwd_b = fwd_ana_use ? min2(fwd_a, ana_pct) : fwd_a;
    wire [PCT_W-1:0] rev_b = rev_ana_use ? min2(rev_a, ana_pct) : rev_a;
    wire [PCT_W-1:0] fwd_lim = min2(fwd_b, motor_max_force);
    wire [PCT_W-1:0] rev_lim = min2(rev_b, motor_max_force);

    // percent to command units: 100 percent = 2**(FORCE_W-4), scale by 4096/100
    wire [FORCE_W+PCT_W-1:0] fwd_mag =
        (FORCE_W+PCT_W)'({fwd_lim, {(FORCE_W-4){1'b0}}} / 100);
    wire [FORCE_W+PCT_W-1:0] rev_mag =
        (FORCE_W+PCT_W)'({rev_lim, {(FORCE_W-4){1'b0}}} / 100);
    localparam logic [FORCE_W+PCT_W-1:0] POS_TOP = (FORCE_W+PCT_W)'(2**(FORCE_W-1) - 1);
    wire [FORCE_W-1:0] fwd_cap = (fwd_mag > POS_TOP) ? FORCE_W'(POS_TOP) : FORCE_W'(fwd_mag);
    wire [FORCE_W-1:0] rev_cap = (rev_mag > POS_TOP) ? FORCE_W'(POS_TOP) : FORCE_W'(rev_mag);
    wire signed [FORCE_W-1:0] fwd_s = $signed(fwd_cap);
    wire signed [FORCE_W-1:0] rev_s = -$signed(rev_cap);
    wire clamp_hi = !force_cmd[FORCE_W-1] && (force_cmd > fwd_s);
    wire clamp_lo = force_cmd[FORCE_W-1] && (force_cmd < rev_s);
    wire signed [FORCE_W-1:0] force_next = clamp_hi ? fwd_s : clamp_lo ? rev_s : force_cmd;
    wire limiting = clamp_hi | clamp_lo;

    // output terminal allocation, 0 leaves the flag unconnected
    logic [NUM_OUT-1:0] out_next;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
            assign out_next[gi] = !(limiting &&
                output_signal_alloc_param == 4'(gi + 1));
        end
    endgenerate

    // registered outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            force_out <= '0;
            fwd_limit_eff <= INT_LIMIT_RST;
            rev_limit_eff <= INT_LIMIT_RST;
            force_limited_out_n <= 1'b1;
            out_term_n <= '1;
            ff_enable <= 1'b0;
            ctrl_mode <= MODE_SPEED;
        end else begin
            force_out <= force_next;
            fwd_limit_eff <= fwd_lim;
            rev_limit_eff <= rev_lim;
            force_limited_out_n <= !limiting;
            out_term_n <= out_next;
            ff_enable <= (speed_ctrl_option_param == OPT_FEED_FWD) && !force_mode;
            ctrl_mode <= mode_next;
        end
    end

    // checks
    sequence s_clamp_seen;
        limiting;
    endsequence
    AST_FLAG: assert property (@(posedge clk) disable iff (srst)
        s_clamp_seen |=> !force_limited_out_n) else $error("limit flag not low");
    AST_FLAG_OFF: assert property (@(posedge clk) disable iff (srst)
        !limiting |=> force_limited_out_n) else $error("limit flag not high");
    AST_NO_FF_ANA: assert property (@(posedge clk) disable iff (srst)
        ff_enable |-> !fwd_ana_use && !rev_ana_use) else $error("ff with analog");
    AST_FORCE_MODE: assert property (@(posedge clk) disable iff (srst)
        force_mode |-> !fwd_ana_use && !rev_ana_use) else $error("analog in force mode");
    AST_FWD_OFF: assert property (@(posedge clk) disable iff (srst)
        !fwd_on_reg && !fwd_ana_use |-> fwd_lim == min2(fwd_int, motor_max_force))
        else $error("fwd limit wrong");
    AST_REV_ON: assert property (@(posedge clk) disable iff (srst)
        rev_on_reg |-> rev_lim <= rev_ext && rev_lim <= rev_int) else $error("rev limit wrong");
    AST_MAX: assert property (@(posedge clk) disable iff (srst)
        ##1 fwd_limit_eff <= $past(motor_max_force) && rev_limit_eff <= $past(motor_max_force))
        else $error("motor max exceeded");
    AST_FILT: assert property (@(posedge clk) disable iff (srst)
        fwd_raw_on [*5] |-> fwd_on_reg) else $error("fwd input not taken");
    AST_MODE8: assert property (@(posedge clk) disable iff (srst)
        control_mode_pair_param == 4'h8 && !mode_select_in_n |=> ctrl_mode == MODE_FORCE)
        else $error("mode 8 wrong");
    AST_OUT: assert property (@(posedge clk) disable iff (srst)
        output_signal_alloc_param == ALLOC_NONE |=> out_term_n == '1) else $error("flag leaked");

    // limit input filter: bounded wait, both edges, both inputs
    sequence s_fwd_gone;
        !fwd_raw_on [*5];
    endsequence
    sequence s_rev_held;
        rev_raw_on [*5];
    endsequence
    sequence s_rev_gone;
        !rev_raw_on [*5];
    endsequence
    AST_FILT_BOUND: assert property (@(posedge clk) disable iff (srst)
        fwd_cnt_reg <= FILT_TOP && rev_cnt_reg <= FILT_TOP)
        else $error("limit input filter overran");
    AST_FWD_DROP: assert property (@(posedge clk) disable iff (srst)
        s_fwd_gone |-> !fwd_on_reg)
        else $error("fwd input release not taken");
    AST_REV_TAKE: assert property (@(posedge clk) disable iff (srst)
        s_rev_held |-> rev_on_reg)
        else $error("rev input not taken");
    AST_REV_DROP: assert property (@(posedge clk) disable iff (srst)
        s_rev_gone |-> !rev_on_reg)
        else $error("rev input release not taken");
    AST_FWD_STEADY: assert property (@(posedge clk) disable iff (srst)
        $rose(fwd_on_reg) |-> $past(fwd_raw_on, 1) && $past(fwd_raw_on, 4))
        else $error("fwd input glitch taken");

    // analog limit routing per option and control mode
    AST_OPT1_USE: assert property (@(posedge clk) disable iff (srst)
        opt_ana && ana_ok |-> fwd_ana_use && rev_ana_use)
        else $error("option 1 analog limit unused");
    AST_OPT3_USE: assert property (@(posedge clk) disable iff (srst)
        opt_comb && ana_ok |-> fwd_ana_use == fwd_on_reg && rev_ana_use == rev_on_reg)
        else $error("option 3 analog limit not tied to inputs");
    AST_OPT_OTHER: assert property (@(posedge clk) disable iff (srst)
        !opt_ana && !opt_comb |-> !fwd_ana_use && !rev_ana_use)
        else $error("analog limit without option");
    AST_FF_ON: assert property (@(posedge clk) disable iff (srst)
        speed_ctrl_option_param == OPT_FEED_FWD && !force_mode |=> ff_enable)
        else $error("feed-forward not enabled");
    AST_FF_OFF: assert property (@(posedge clk) disable iff (srst)
        speed_ctrl_option_param != OPT_FEED_FWD || force_mode |=> !ff_enable)
        else $error("feed-forward enabled wrongly");

    // analog scaling: gain held in range, polarity ignored
    AST_GAIN_RANGE: assert property (@(posedge clk) disable iff (srst)
        gain_c >= GAIN_MIN && gain_c <= GAIN_MAX)
        else $error("gain out of range");
    AST_ANA_RANGE: assert property (@(posedge clk) disable iff (srst)
        ana_pct <= PCT_MAX)
        else $error("analog limit above range");
    AST_ABS_SIGN: assert property (@(posedge clk) disable iff (srst)
        !abs_ref[ANALOG_W-1] || force_ref_analog == -(2**(ANALOG_W-1)))
        else $error("analog magnitude negative");

    // limit composition: every applicable source bounds the result
    AST_INT_ALWAYS: assert property (@(posedge clk) disable iff (srst)
        fwd_lim <= fwd_int && rev_lim <= rev_int)
        else $error("internal limit exceeded");
    AST_EXT_RANGE: assert property (@(posedge clk) disable iff (srst)
        fwd_ext <= PCT_MAX && rev_ext <= PCT_MAX && fwd_int <= PCT_MAX && rev_int <= PCT_MAX)
        else $error("setting above range");
    AST_FWD_ON: assert property (@(posedge clk) disable iff (srst)
        fwd_on_reg |-> fwd_lim <= fwd_ext && fwd_lim <= fwd_int)
        else $error("fwd external limit ignored");
    AST_REV_OFF: assert property (@(posedge clk) disable iff (srst)
        !rev_on_reg && !rev_ana_use |-> rev_lim == min2(rev_int, motor_max_force))
        else $error("rev limit wrong while input off");
    AST_FWD_COMB: assert property (@(posedge clk) disable iff (srst)
        fwd_on_reg && fwd_ana_use |-> fwd_lim <= ana_pct && fwd_lim <= fwd_ext)
        else $error("fwd combined limit not smallest");
    AST_REV_COMB: assert property (@(posedge clk) disable iff (srst)
        rev_on_reg && rev_ana_use |-> rev_lim <= ana_pct && rev_lim <= rev_ext)
        else $error("rev combined limit not smallest");
    AST_ANA_BOTH: assert property (@(posedge clk) disable iff (srst)
        fwd_ana_use && rev_ana_use |-> fwd_lim <= ana_pct && rev_lim <= ana_pct)
        else $error("analog limit not applied both ways");

    // command clamp and flag routing
    AST_CLAMP_FWD: assert property (@(posedge clk) disable iff (srst)
        clamp_hi |=> force_out == $past(fwd_s))
        else $error("forward clamp wrong");
    AST_CLAMP_REV: assert property (@(posedge clk) disable iff (srst)
        clamp_lo |=> force_out == $past(rev_s))
        else $error("reverse clamp wrong");
    AST_PASS: assert property (@(posedge clk) disable iff (srst)
        !limiting |=> force_out == $past(force_cmd))
        else $error("command altered without limit");
    AST_OUT_ON: assert property (@(posedge clk) disable iff (srst)
        limiting && output_signal_alloc_param == 4'h1 |=> !out_term_n[0])
        else $error("allocated flag not low");
    AST_OUT_IDLE: assert property (@(posedge clk) disable iff (srst)
        !limiting |=> out_term_n == '1)
        else $error("flag terminal low without limit");
    AST_SHARED: assert property (@(posedge clk) disable iff (srst)
        |(~term_in_n & fwd_limit_extra_map) |-> fwd_raw_on)
        else $error("shared terminal not combined");

    // control mode pair decode
    AST_MODE4: assert property (@(posedge clk) disable iff (srst)
        control_mode_pair_param == 4'h4 && !fwd_on_reg && !rev_on_reg && mode_select_in_n
        |=> ctrl_mode == MODE_SPEED)
        else $error("mode 4 wrong");
    AST_MODE5: assert property (@(posedge clk) disable iff (srst)
        control_mode_pair_param == 4'h5 && !mode_select_in_n |=> ctrl_mode == MODE_INT_SPEED)
        else $error("mode 5 wrong");
    AST_MODE6: assert property (@(posedge clk) disable iff (srst)
        control_mode_pair_param == 4'h6 && !fwd_on_reg && !rev_on_reg && mode_select_in_n
        |=> ctrl_mode == MODE_FORCE)
        else $error("mode 6 wrong");
    AST_MODE9: assert property (@(posedge clk) disable iff (srst)
        control_mode_pair_param == 4'h9 && mode_select_in_n |=> ctrl_mode == MODE_FORCE)
        else $error("mode 9 wrong");
    AST_MODEA: assert property (@(posedge clk) disable iff (srst)
        control_mode_pair_param == 4'ha && !mode_select_in_n |=> ctrl_mode == MODE_ZERO_CLAMP)
        else $error("mode A wrong");
    AST_MODEB: assert property (@(posedge clk) disable iff (srst)
        control_mode_pair_param == 4'hb && !mode_select_in_n |=> ctrl_mode == MODE_INHIBIT)
        else $error("mode B wrong");
endmodule : force_limit_selector
